// ### include/usb_desc_regs_pkg.sv
/*
  Package for the descriptor table base and configuration register bank:
  register offsets, field positions, widths and reset values.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
`default_nettype none

package usb_desc_regs_pkg;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_PAGE_LOW  = 8'h00;
  localparam logic [7:0] OFS_PAGE_MID  = 8'h04;
  localparam logic [7:0] OFS_PAGE_HIGH = 8'h08;
  localparam logic [7:0] OFS_CONFIG    = 8'h0c;
  localparam int         ADDR_DEC_W    = 8;

  // Page low field: bits 7..1 hold table base bits 15..9
  localparam int LOW_FIELD_LSB  = 1;
  localparam int LOW_FIELD_MSB  = 7;
  localparam int LOW_FIELD_W    = 7;
  localparam int BYTE_FIELD_W   = 8;
  localparam int ALIGN_BITS     = 9;

  // Configuration bit positions
  localparam int CFG_EYE_BIT    = 7;
  localparam int CFG_OEMON_BIT  = 6;
  localparam int CFG_SIDL_BIT   = 4;
  localparam int CFG_ASUSP_BIT  = 0;

  // Reset values
  localparam logic [6:0] RST_LOW   = 7'h00;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic       RST_BIT   = 1'b0;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HTRANS_ACTIVE_BIT = 1'b1;
  localparam logic       HRESP_OKAY    = 1'b0;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

endpackage

`default_nettype wire

// ### rtl/usb_desc_regs.sv
/*
  Register bank holding the buffer descriptor table base pointer and the
  first configuration register of a full-speed USB controller.
  Assumes a single AHB-Lite master, word transfers, one clock domain and a
  synchronous active-low reset. Idle and sleep indications come from logic
  on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1: Table base bits 15..9 come from bits 7..1 of the page low register.
// R2: Table base bits 23..16 come from bits 7..0 of the page mid register.
// R3: Table base bits 31..24 come from bits 7..0 of the page high register.
// R4: The assembled 32-bit table base is 512-byte aligned, its low nine bits zero.
// R5: Bits 31..8 of every register and bit 0 of the page low register read as zero.
// R6: Config bit 7 enables the transceiver eye-pattern test output.
// R7: With config bit 6 set, the output-enable monitor follows the line drive.
// R8: With config bit 4 set, the USB module halts while the chip is idle.
// R9: With config bit 0 set, the USB module suspends itself on entry to sleep.
// R10: Without auto suspend, software sets the manual suspend bit before sleep.
// R11: All writable fields clear to zero on reset.
// R12: Writes to unimplemented bit positions are ignored.
module usb_desc_regs (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Chip power state and transceiver activity
  input  wire logic        chip_idle_i,
  input  wire logic        chip_sleep_i,
  input  wire logic        manual_suspend_i,
  input  wire logic        line_drive_i,
  // Controls to the USB module
  output logic      [31:0] table_base_o,
  output logic             eye_pattern_test_enable_o,
  output logic             output_enable_monitor_o,
  output logic             module_halt_o,
  output logic             module_suspend_o
);

  // Stored fields
  logic [6:0] table_base_bits_low;
  logic [7:0] table_base_bits_mid;
  logic [7:0] table_base_bits_high;
  logic       eye_pattern_test_enable;
  logic       output_enable_monitor_enable;
  logic       stop_in_idle;
  logic       auto_suspend_on_sleep;

  // Captured address phase
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       addr_valid;

  // Writes are posted one cycle, so hreadyout never needs to stall
  assign addr_valid  = hsel_i && hready_i && htrans_i[1] == usb_desc_regs_pkg::HTRANS_ACTIVE_BIT;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = usb_desc_regs_pkg::HRESP_OKAY;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_valid && hwrite_i;
      if (addr_valid) begin
        wr_addr <= haddr_i[usb_desc_regs_pkg::ADDR_DEC_W-1:0];
      end
    end
  end

  // Only the implemented bit positions of hwdata are stored
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      table_base_bits_low  <= usb_desc_regs_pkg::RST_LOW;  // R11
      table_base_bits_mid  <= usb_desc_regs_pkg::RST_BYTE; // R11
      table_base_bits_high <= usb_desc_regs_pkg::RST_BYTE; // R11
    end else if (wr_pend) begin
      unique case (wr_addr)
        usb_desc_regs_pkg::OFS_PAGE_LOW:
          table_base_bits_low <= hwdata_i[usb_desc_regs_pkg::LOW_FIELD_MSB:
                                          usb_desc_regs_pkg::LOW_FIELD_LSB]; // R12
        usb_desc_regs_pkg::OFS_PAGE_MID:
          table_base_bits_mid <= hwdata_i[usb_desc_regs_pkg::BYTE_FIELD_W-1:0]; // R12
        usb_desc_regs_pkg::OFS_PAGE_HIGH:
          table_base_bits_high <= hwdata_i[usb_desc_regs_pkg::BYTE_FIELD_W-1:0]; // R12
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      eye_pattern_test_enable      <= usb_desc_regs_pkg::RST_BIT; // R11
      output_enable_monitor_enable <= usb_desc_regs_pkg::RST_BIT; // R11
      stop_in_idle                 <= usb_desc_regs_pkg::RST_BIT; // R11
      auto_suspend_on_sleep        <= usb_desc_regs_pkg::RST_BIT; // R11
    end else if (wr_pend && wr_addr == usb_desc_regs_pkg::OFS_CONFIG) begin
      eye_pattern_test_enable      <= hwdata_i[usb_desc_regs_pkg::CFG_EYE_BIT];   // R6
      output_enable_monitor_enable <= hwdata_i[usb_desc_regs_pkg::CFG_OEMON_BIT]; // R7
      stop_in_idle                 <= hwdata_i[usb_desc_regs_pkg::CFG_SIDL_BIT];  // R8
      auto_suspend_on_sleep        <= hwdata_i[usb_desc_regs_pkg::CFG_ASUSP_BIT]; // R9
    end
  end

  // Read data registered at the end of the address phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= usb_desc_regs_pkg::RDATA_ZERO;
    end else if (addr_valid && !hwrite_i) begin
      hrdata_o <= usb_desc_regs_pkg::RDATA_ZERO; // R5
      unique case (haddr_i[usb_desc_regs_pkg::ADDR_DEC_W-1:0])
        usb_desc_regs_pkg::OFS_PAGE_LOW:
          hrdata_o[usb_desc_regs_pkg::LOW_FIELD_MSB:
                   usb_desc_regs_pkg::LOW_FIELD_LSB] <= table_base_bits_low; // R5
        usb_desc_regs_pkg::OFS_PAGE_MID:
          hrdata_o[usb_desc_regs_pkg::BYTE_FIELD_W-1:0] <= table_base_bits_mid;
        usb_desc_regs_pkg::OFS_PAGE_HIGH:
          hrdata_o[usb_desc_regs_pkg::BYTE_FIELD_W-1:0] <= table_base_bits_high;
        usb_desc_regs_pkg::OFS_CONFIG: begin
          hrdata_o[usb_desc_regs_pkg::CFG_EYE_BIT]   <= eye_pattern_test_enable;
          hrdata_o[usb_desc_regs_pkg::CFG_OEMON_BIT] <= output_enable_monitor_enable;
          hrdata_o[usb_desc_regs_pkg::CFG_SIDL_BIT]  <= stop_in_idle;
          hrdata_o[usb_desc_regs_pkg::CFG_ASUSP_BIT] <= auto_suspend_on_sleep;
        end
        default: ;
      endcase
    end
  end

  // Controls toward the USB module, all registered
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      table_base_o              <= 32'h0000_0000;
      eye_pattern_test_enable_o <= 1'b0;
      output_enable_monitor_o   <= 1'b0;
      module_halt_o             <= 1'b0;
      module_suspend_o          <= 1'b0;
    end else begin
      table_base_o <= {table_base_bits_high,                  // R3
                       table_base_bits_mid,                   // R2
                       table_base_bits_low,                   // R1
                       {usb_desc_regs_pkg::ALIGN_BITS{1'b0}}}; // R4
      eye_pattern_test_enable_o <= eye_pattern_test_enable; // R6
      output_enable_monitor_o   <= output_enable_monitor_enable && line_drive_i; // R7
      module_halt_o             <= stop_in_idle && chip_idle_i; // R8
      // Manual suspend stays effective whatever the auto setting; R10 is software's part
      module_suspend_o <= (auto_suspend_on_sleep && chip_sleep_i) || manual_suspend_i; // R9
    end
  end

endmodule // usb_desc_regs

`default_nettype wire

// ### sim/usb_desc_regs_sva.sv
/* Checker for the descriptor base and configuration bank.
   Assumes it is bound to usb_desc_regs and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module usb_desc_regs_sva (
  input wire logic        core_clk_i, rst_n_i, hsel_i, hwrite_i, hready_i,
  input wire logic [1:0]  htrans_i,
  input wire logic [31:0] haddr_i, hwdata_i, hrdata_o, table_base_o,
  input wire logic        chip_idle_i, chip_sleep_i, manual_suspend_i, line_drive_i,
  input wire logic        eye_pattern_test_enable_o, output_enable_monitor_o,
  input wire logic        module_halt_o, module_suspend_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       rq, wr;
  logic [7:0] a;
  assign rq = hsel_i && hready_i && htrans_i[1];
  assign wr = rq && hwrite_i;
  assign a  = haddr_i[7:0];
  // Write lands at the end of the data phase; the registered output is seen one edge later
  property p_low; wr && a == 8'h00 |=> ##2 table_base_o[15:9] == $past(hwdata_i[7:1], 2); endproperty
  a_low: assert property (p_low) else $error("page low field wrong");
  property p_mid; wr && a == 8'h04 |=> ##2 table_base_o[23:16] == $past(hwdata_i[7:0], 2); endproperty
  a_mid: assert property (p_mid) else $error("page mid field wrong");
  property p_hi; wr && a == 8'h08 |=> ##2 table_base_o[31:24] == $past(hwdata_i[7:0], 2); endproperty
  a_hi: assert property (p_hi) else $error("page high field wrong");
  property p_al; table_base_o[8:0] == 9'h000; endproperty
  a_al: assert property (p_al) else $error("table base not aligned");
  property p_rz; rq && !hwrite_i |=> hrdata_o[31:8] == 24'h000000; endproperty
  a_rz: assert property (p_rz) else $error("upper read bits set");
  property p_eye; wr && a == 8'h0c |=> ##2 eye_pattern_test_enable_o == $past(hwdata_i[7], 2);
  endproperty
  a_eye: assert property (p_eye) else $error("eye enable wrong");
  property p_oem; output_enable_monitor_o |-> $past(line_drive_i); endproperty
  a_oem: assert property (p_oem) else $error("monitor without drive");
  property p_hlt; module_halt_o |-> $past(chip_idle_i); endproperty
  a_hlt: assert property (p_hlt) else $error("halt outside idle");
  property p_sus; module_suspend_o |-> $past(chip_sleep_i) || $past(manual_suspend_i); endproperty
  a_sus: assert property (p_sus) else $error("suspend without cause");
endmodule // usb_desc_regs_sva
bind usb_desc_regs usb_desc_regs_sva usb_desc_regs_sva_i (.*);
`default_nettype wire

// ### sim/usb_desc_regs_tb_top.sv
/* Self-checking bench for usb_desc_regs.
   Assumes one AHB-Lite slave whose hreadyout loops back as hready. */
`timescale 1ns/1ns
`default_nettype none
module usb_desc_regs_tb_top;
  logic        clk, rst_n, sel, wr, rdy, resp, idle, sleep, man, drv, eye, oem, halt, susp;
  logic [1:0]  tr;
  logic [31:0] ad, wd, rd, base, r;
  int          fails, n_compared;
  usb_desc_regs usb_desc_regs_i (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(sel),
    .haddr_i(ad), .htrans_i(tr), .hwrite_i(wr), .hsize_i(3'h2), .hwdata_i(wd),
    .hready_i(rdy), .hrdata_o(rd), .hreadyout_o(rdy), .hresp_o(resp), .chip_idle_i(idle),
    .chip_sleep_i(sleep), .manual_suspend_i(man), .line_drive_i(drv), .table_base_o(base),
    .eye_pattern_test_enable_o(eye), .output_enable_monitor_o(oem), .module_halt_o(halt),
    .module_suspend_o(susp));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task results;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end
  endtask
  task chk_b(input string n, input logic e, g);
    n_compared++;
    if (g !== e) begin fails++; $display("BAD %s exp %b got %b", n, e, g); end
  endtask
  // Bounded wait for hready; a hang ends the run
  task wt;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 20);
    if (rdy !== 1'b1) begin fails++; results; end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1; ad <= {24'h0, a}; tr <= 2'h2; wr <= w;
    wt;
    sel <= 0; tr <= 2'h0; wd <= d;
    wt;
    r = rd;
  endtask
  task rck(input logic [7:0] a, input logic [31:0] e, input string n);
    ahb(0, a, 32'h0);
    chk(n, e, r);
    chk_b("hresp", 1'b0, resp);
  endtask
  // Outputs settle one edge after a register or input change; ob waits two edges
  task ob(input logic [3:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk_b("eye", e[3], eye); chk_b("oem", e[2], oem);
    chk_b("halt", e[1], halt); chk_b("susp", e[0], susp);
  endtask
  task t_reset;
    for (int i = 0; i < 5; i++) rck(8'(i * 4), 32'h0, "reset read");
    chk("base", 32'h0, base);
    ob(4'h0);
  endtask
  task t_pages;
    ahb(1, 8'h00, 32'hffff_ff25); ahb(1, 8'h04, 32'h0000_01c3);
    ahb(1, 8'h08, 32'h1234_563c); ahb(1, 8'h10, 32'hffff_ffff);
    rck(8'h00, 32'h24, "low");
    rck(8'h04, 32'hc3, "mid");
    rck(8'h08, 32'h3c, "high");
    rck(8'h10, 32'h0, "unmapped");
    chk("base", 32'h3cc3_2400, base);
  endtask
  task t_cfg;
    ahb(1, 8'h0c, 32'hffff_ffff);
    rck(8'h0c, 32'hd1, "cfg");
    ob(4'h8);
    @(posedge clk);
    drv <= 1; idle <= 1; sleep <= 1;
    ob(4'hf);
    ahb(1, 8'h0c, 32'h80);
    ob(4'h8);
    @(posedge clk);
    man <= 1;
    ahb(1, 8'h0c, 32'h0);
    ob(4'h1);
  endtask
  initial begin
    rst_n = 0; sel = 0; wr = 0; tr = 0; ad = 0; wd = 0;
    idle = 0; sleep = 0; man = 0; drv = 0; fails = 0; n_compared = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_pages;
    t_cfg;
    results;
  end
endmodule // usb_desc_regs_tb_top
`default_nettype wire
